// >>> tbms_pkg.sv
// Package for the tuner bias mode sequencer: register layouts, reset values, mode codes.
// Assumes one 20 MHz clock; register writes arrive already decoded from the serial front end.
package tbms_pkg;

  localparam int unsigned NUM_OUTPUTS    = 6;
  localparam int unsigned CODE_W         = 7;
  localparam int unsigned BOOST_W        = 4;
  localparam int unsigned MODE_W         = 2;

  // Register selectors on the decoded write port (no printed offsets exist)
  localparam logic [3:0] SEL_BOOST       = 4'h0;
  localparam logic [3:0] SEL_MODE        = 4'h1;
  localparam logic [3:0] SEL_ENABLE      = 4'h2;
  localparam logic [3:0] SEL_CODE_BASE   = 4'h8;

  localparam logic [BOOST_W-1:0] BOOST_RESET  = 4'hf;
  localparam logic [NUM_OUTPUTS-1:0] ENABLE_RESET = 6'h00;
  localparam logic [CODE_W-1:0] CODE_RESET    = 7'h00;
  localparam logic [CODE_W-1:0] CODE_PULLDOWN = 7'h00;

  localparam logic [MODE_W-1:0] MODE_ACTIVE   = 2'h0;
  localparam logic [MODE_W-1:0] MODE_STARTUP  = 2'h1;
  localparam logic [MODE_W-1:0] MODE_LOWPOWER = 2'h2;

  // Startup dwell: 300 us longest startup time, rounded down to cycles
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned STARTUP_US      = 300;
  localparam int unsigned STARTUP_CYCLES  = (STARTUP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned STARTUP_CNT_W   = 13;

  typedef enum logic [3:0] {
    TBMS_SHUTDOWN = 4'b0001,
    TBMS_STARTUP  = 4'b0010,
    TBMS_ACTIVE   = 4'b0100,
    TBMS_LOWPOWER = 4'b1000
  } tbms_state_e;

  typedef struct packed {
    logic       valid;
    logic [3:0] sel;
    logic [7:0] data;
  } tbms_wr_s;

  typedef struct packed {
    logic [NUM_OUTPUTS-1:0]             drive_en;
    logic [NUM_OUTPUTS-1:0]             pulldown_en;
    logic [NUM_OUTPUTS*CODE_W-1:0]      codes;
  } tbms_out_s;

endpackage

// >>> tbms_sequencer.sv
// Operating-mode and reset sequencer for a six-output bias controller.
// Assumes supply levels arrive as async pins; writes arrive decoded, clk domain.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Shutdown: all blocks off, outputs high impedance
// - Shutdown on analog supply low or low IO
// - Registers lost in shutdown, defaults after
// - IO high: startup, reset, boost on, outputs off
// - Startup advances to active on its own
// - Startup command forces full reset, back active
// - Active: each output off until enabled
// - Active to low-power only by command
// - Low-power: serial on, outputs off, boost off
// - Low-power keeps all register contents
// - Low-power to active by active command
// - Zero code disables output, selects pull-down
// - Seven-bit code, 128 levels of 188 mV
// - Four-bit boost level, 9 V to 24 V
// - Boost level resets to all ones
// - IO power-on reset also resets serial receiver
// - Power-on reset only on IO low-to-high
// - Mode field reads startup then active
// - Shutdown holds six outputs high impedance
module tbms_sequencer (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    analog_supply_level,
  input  wire logic                    io_supply_level,
  input  wire tbms_pkg::tbms_wr_s      wr,
  output var  tbms_pkg::tbms_out_s     outs,
  output var  logic [3:0]              boost_level_q,
  output var  logic                    boost_run_q,
  output var  logic [1:0]              power_state_q,
  output var  logic [5:0]              output_enables_q,
  output var  logic                    serial_enable_q,
  output var  logic                    serial_reset_q,
  output var  logic                    core_on_q
);

  tbms_pkg::tbms_state_e state_q;
  tbms_pkg::tbms_state_e state_d;
  logic [2:0]  io_sync_q;
  logic [2:0]  av_sync_q;
  logic        io_level_q;
  logic        av_level_q;
  logic        io_now;
  logic        av_now;
  logic        io_rise;
  logic        io_fall;
  logic        cmd_startup;
  logic        cmd_active;
  logic        cmd_lowpower;
  logic        soft_reset;
  logic        regs_clear;
  logic [12:0] start_cnt_q;
  logic [12:0] startup_age_q;
  logic [6:0]  code_q [6];

  function automatic logic is_code_sel(input logic [3:0] sel);
    is_code_sel = (sel >= tbms_pkg::SEL_CODE_BASE) &&
                  (sel < tbms_pkg::SEL_CODE_BASE + 4'h6);
  endfunction

  // Three-stage sync; level changes once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_sync_q <= 3'h0;
      av_sync_q <= 3'h0;
    end else begin
      io_sync_q <= {io_sync_q[1:0], io_supply_level};
      av_sync_q <= {av_sync_q[1:0], analog_supply_level};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_level_q <= 1'b0;
      av_level_q <= 1'b0;
    end else begin
      if (io_sync_q[2] == io_sync_q[1]) begin
        io_level_q <= io_sync_q[2];
      end
      if (av_sync_q[2] == av_sync_q[1]) begin
        av_level_q <= av_sync_q[2];
      end
    end
  end

  // Agreed level this cycle; io_level_q trails it by one, which gives the edge
  assign io_now  = (io_sync_q[2] == io_sync_q[1]) ? io_sync_q[2] : io_level_q;
  assign av_now  = (av_sync_q[2] == av_sync_q[1]) ? av_sync_q[2] : av_level_q;
  // Edge only, so a held-high supply never retriggers
  assign io_rise = io_now && !io_level_q;
  // Fresh level, else the rise cycle itself would look like a supply loss
  assign io_fall = !io_now || !av_now;

  assign cmd_startup  = wr.valid && (wr.sel == tbms_pkg::SEL_MODE) &&
                        (wr.data[1:0] == tbms_pkg::MODE_STARTUP);
  assign cmd_active   = wr.valid && (wr.sel == tbms_pkg::SEL_MODE) &&
                        (wr.data[1:0] == tbms_pkg::MODE_ACTIVE);
  assign cmd_lowpower = wr.valid && (wr.sel == tbms_pkg::SEL_MODE) &&
                        (wr.data[1:0] == tbms_pkg::MODE_LOWPOWER);
  assign soft_reset   = cmd_startup && ((state_q == tbms_pkg::TBMS_ACTIVE) ||
                        (state_q == tbms_pkg::TBMS_LOWPOWER));
  // Registers held at defaults in shutdown and startup
  assign regs_clear   = (state_q == tbms_pkg::TBMS_SHUTDOWN) ||
                        (state_q == tbms_pkg::TBMS_STARTUP) || soft_reset;

  always_comb begin
    state_d = state_q;
    case (state_q)
      tbms_pkg::TBMS_SHUTDOWN: begin
        if (io_rise && av_now) begin
          state_d = tbms_pkg::TBMS_STARTUP;
        end
      end
      tbms_pkg::TBMS_STARTUP: begin
        if (start_cnt_q == 13'(tbms_pkg::STARTUP_CYCLES - 1)) begin
          state_d = tbms_pkg::TBMS_ACTIVE;
        end
      end
      tbms_pkg::TBMS_ACTIVE: begin
        if (soft_reset) begin
          state_d = tbms_pkg::TBMS_STARTUP;
        end else if (cmd_lowpower) begin
          state_d = tbms_pkg::TBMS_LOWPOWER;
        end
      end
      tbms_pkg::TBMS_LOWPOWER: begin
        if (soft_reset) begin
          state_d = tbms_pkg::TBMS_STARTUP;
        end else if (cmd_active) begin
          state_d = tbms_pkg::TBMS_ACTIVE;
        end
      end
      default: state_d = tbms_pkg::TBMS_SHUTDOWN;
    endcase
    if (io_fall) begin
      state_d = tbms_pkg::TBMS_SHUTDOWN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= tbms_pkg::TBMS_SHUTDOWN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_cnt_q <= 13'h0000;
    end else if (state_q != tbms_pkg::TBMS_STARTUP || state_d != tbms_pkg::TBMS_STARTUP) begin
      start_cnt_q <= 13'h0000;
    end else begin
      start_cnt_q <= start_cnt_q + 13'h0001;
    end
  end

  // Checker aid: startup age, saturating so a stuck startup cannot wrap back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startup_age_q <= 13'h0000;
    end else if (state_q != tbms_pkg::TBMS_STARTUP) begin
      startup_age_q <= 13'h0000;
    end else if (startup_age_q != 13'h1fff) begin
      startup_age_q <= startup_age_q + 13'h0001;
    end
  end

  // Writes accepted in active and low-power; low-power keeps contents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boost_level_q    <= tbms_pkg::BOOST_RESET;
      output_enables_q <= tbms_pkg::ENABLE_RESET;
    end else if (regs_clear) begin
      boost_level_q    <= tbms_pkg::BOOST_RESET;
      output_enables_q <= tbms_pkg::ENABLE_RESET;
    end else if (wr.valid && wr.sel == tbms_pkg::SEL_BOOST) begin
      boost_level_q    <= wr.data[3:0];
    end else if (wr.valid && wr.sel == tbms_pkg::SEL_ENABLE) begin
      output_enables_q <= wr.data[5:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) begin
        code_q[i] <= tbms_pkg::CODE_RESET;
      end
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (regs_clear) begin
          code_q[i] <= tbms_pkg::CODE_RESET;
        end else if (wr.valid && is_code_sel(wr.sel) &&
                     wr.sel[2:0] == 3'(i)) begin
          code_q[i] <= wr.data[6:0];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_state_q <= tbms_pkg::MODE_STARTUP;
    end else begin
      case (state_d)
        tbms_pkg::TBMS_ACTIVE:   power_state_q <= tbms_pkg::MODE_ACTIVE;
        tbms_pkg::TBMS_LOWPOWER: power_state_q <= tbms_pkg::MODE_LOWPOWER;
        default:                 power_state_q <= tbms_pkg::MODE_STARTUP;
      endcase
    end
  end

  // Outputs driven only in active mode; a zero code pulls down instead
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outs <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        outs.codes[i*7 +: 7] <= code_q[i];
        if (state_d == tbms_pkg::TBMS_ACTIVE && !regs_clear && output_enables_q[i]) begin
          outs.drive_en[i]    <= (code_q[i] != tbms_pkg::CODE_PULLDOWN);
          outs.pulldown_en[i] <= (code_q[i] == tbms_pkg::CODE_PULLDOWN);
        end else begin
          outs.drive_en[i]    <= 1'b0;
          outs.pulldown_en[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boost_run_q     <= 1'b0;
      serial_enable_q <= 1'b0;
      serial_reset_q  <= 1'b1;
      core_on_q       <= 1'b0;
    end else begin
      boost_run_q     <= (state_d == tbms_pkg::TBMS_STARTUP) ||
                         (state_d == tbms_pkg::TBMS_ACTIVE);
      serial_enable_q <= (state_d != tbms_pkg::TBMS_SHUTDOWN);
      serial_reset_q  <= (state_d == tbms_pkg::TBMS_SHUTDOWN) || io_rise;
      core_on_q       <= (state_d != tbms_pkg::TBMS_SHUTDOWN);
    end
  end

  shutdown_hiz_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == tbms_pkg::TBMS_SHUTDOWN) |=> ((outs.drive_en | outs.pulldown_en) == 6'h00))
    else $error("output driven in shutdown");
  lowpower_off_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == tbms_pkg::TBMS_LOWPOWER) |-> !boost_run_q || $past(state_q) != state_q)
    else $error("boost running in low power");
  io_low_sd_a: assert property (@(posedge clk) disable iff (rst)
    (io_sync_q[2:1] == 2'h0) |=> (state_q == tbms_pkg::TBMS_SHUTDOWN))
    else $error("no shutdown on low io");
  startup_exit_a: assert property (@(posedge clk) disable iff (rst)
    startup_age_q <= 13'(tbms_pkg::STARTUP_CYCLES))
    else $error("startup not transitory");
  boost_default_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == tbms_pkg::TBMS_STARTUP) |=> (boost_level_q == 4'hf))
    else $error("boost not reset to all ones");
  enable_clear_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == tbms_pkg::TBMS_STARTUP) |=> (output_enables_q == 6'h00))
    else $error("enables not cleared");
  soft_reset_a: assert property (@(posedge clk) disable iff (rst)
    (soft_reset && !io_fall) |=> (state_q == tbms_pkg::TBMS_STARTUP))
    else $error("startup command ignored");
  lp_entry_a: assert property (@(posedge clk) disable iff (rst)
    $rose(state_q == tbms_pkg::TBMS_LOWPOWER) |-> $past(cmd_lowpower))
    else $error("low power without command");
  pulldown_a: assert property (@(posedge clk) disable iff (rst)
    (outs.drive_en & outs.pulldown_en) == 6'h00)
    else $error("drive and pulldown together");
  mode_read_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == tbms_pkg::TBMS_STARTUP) |-> (power_state_q == 2'h1))
    else $error("mode field not startup");
  serial_rst_a: assert property (@(posedge clk) disable iff (rst)
    io_rise |=> serial_reset_q)
    else $error("serial receiver not reset on io rise");
  lp_retain_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == tbms_pkg::TBMS_LOWPOWER && state_d == tbms_pkg::TBMS_LOWPOWER && !wr.valid)
      |=> $stable({boost_level_q, output_enables_q}))
    else $error("registers changed in low power");

endmodule

`default_nettype wire

// >>> tbms_host.sv
// Host model: issues decoded register writes into the sequencer.
// Assumes the bench calls write() from its main thread; clk is shared.
`timescale 1ns/1ns
`default_nettype none
module tbms_host (
  input  wire logic               clk,
  output var  tbms_pkg::tbms_wr_s wr
);
  initial wr = '0;

  // One-cycle pulse; qualifiers flip once released so stale data never passes as valid
  task automatic write(input logic [3:0] sel, input logic [7:0] data);
    @(posedge clk);
    wr <= {1'b1, sel, data};
    @(posedge clk);
    wr <= {1'b0, ~sel, ~data};
  endtask
endmodule
`default_nettype wire

// >>> tbms_tb.sv
// Self-checking bench for the tuner bias mode sequencer.
// Assumes tbms_pkg and tbms_host are compiled first; supplies driven here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t %s", $time, m); end end
module testbench;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                analog_supply_level = 1'b0;
  logic                io_supply_level = 1'b0;
  tbms_pkg::tbms_wr_s  wr;
  tbms_pkg::tbms_out_s outs;
  logic [3:0]          boost_level_q;
  logic                boost_run_q;
  logic [1:0]          power_state_q;
  logic [5:0]          output_enables_q;
  logic                serial_enable_q;
  logic                serial_reset_q;
  logic                core_on_q;
  int                  mismatches = 0;
  int                  comparisons = 0;

  always #25 clk = ~clk;

  tbms_host tbms_host_i (.clk(clk), .wr(wr));
  tbms_sequencer tbms_sequencer_i (.clk(clk), .rst(rst), .analog_supply_level(analog_supply_level),
    .io_supply_level(io_supply_level), .wr(wr), .outs(outs), .boost_level_q(boost_level_q),
    .boost_run_q(boost_run_q), .power_state_q(power_state_q), .output_enables_q(output_enables_q),
    .serial_enable_q(serial_enable_q), .serial_reset_q(serial_reset_q), .core_on_q(core_on_q));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_mode(input logic [1:0] m, input int lim);
    int i;
    for (i = 0; i < lim && power_state_q !== m; i++) tick(1);
    `CHK(power_state_q, m, "mode not reached in time")
  endtask

  task automatic power_up();
    `CHK(outs, '0, "outputs not high-Z in reset")
    `CHK(boost_level_q, 4'hf, "boost reset value")
    @(posedge clk);
    analog_supply_level <= 1'b1;
    io_supply_level <= 1'b1;
    tick(6);
    `CHK(power_state_q, tbms_pkg::MODE_STARTUP, "startup code")
    `CHK(boost_run_q, 1'b1, "boost off in startup")
    // Dropped: writes are refused until active
    tbms_host_i.write(tbms_pkg::SEL_BOOST, 8'h00);
    wait_mode(tbms_pkg::MODE_ACTIVE, 6100);
    `CHK(boost_level_q, 4'hf, "startup write took effect")
  endtask

  task automatic drive_outputs();
    tbms_host_i.write(tbms_pkg::SEL_CODE_BASE, 8'h7f);
    tbms_host_i.write(tbms_pkg::SEL_CODE_BASE + 4'h1, 8'h00);
    tick(2);
    `CHK(outs.drive_en, 6'h00, "driven before enable")
    tbms_host_i.write(tbms_pkg::SEL_ENABLE, 8'h03);
    tick(2);
    `CHK(outs.drive_en, 6'h01, "enabled output not driven")
    `CHK(outs.pulldown_en, 6'h02, "zero code not pulled down")
    `CHK(outs.codes[6:0], 7'h7f, "top code")
    // Boost 23 V keeps 11 V headroom over the 12 V output
    tbms_host_i.write(tbms_pkg::SEL_CODE_BASE, 8'h40);
    tbms_host_i.write(tbms_pkg::SEL_BOOST, 8'h0e);
    tick(2);
    `CHK(outs.codes[6:0], 7'h40, "code not updated")
    `CHK(boost_level_q, 4'he, "boost write")
  endtask

  task automatic low_power();
    tbms_host_i.write(tbms_pkg::SEL_MODE, 8'h03);
    tick(2);
    `CHK(power_state_q, tbms_pkg::MODE_ACTIVE, "illegal mode accepted")
    tbms_host_i.write(tbms_pkg::SEL_MODE, 8'h02);
    tick(2);
    `CHK(power_state_q, tbms_pkg::MODE_LOWPOWER, "low power code")
    `CHK(boost_run_q, 1'b0, "boost on in low power")
    `CHK(outs.drive_en | outs.pulldown_en, 6'h00, "outputs not high-Z")
    `CHK(serial_enable_q, 1'b1, "serial off in low power")
    `CHK({output_enables_q, boost_level_q}, {6'h03, 4'he}, "registers lost")
    tbms_host_i.write(tbms_pkg::SEL_MODE, 8'h00);
    tick(2);
    `CHK(power_state_q, tbms_pkg::MODE_ACTIVE, "no return to active")
    `CHK(outs.drive_en, 6'h01, "output not restored")
  endtask

  task automatic startup_command();
    tbms_host_i.write(tbms_pkg::SEL_MODE, 8'h01);
    tick(2);
    `CHK(power_state_q, tbms_pkg::MODE_STARTUP, "no startup on command")
    `CHK({output_enables_q, boost_level_q}, {6'h00, 4'hf}, "registers kept")
    `CHK(outs, '0, "outputs not reset")
    wait_mode(tbms_pkg::MODE_ACTIVE, 6100);
  endtask

  task automatic supply_loss();
    tbms_host_i.write(tbms_pkg::SEL_ENABLE, 8'h3f);
    @(posedge clk);
    io_supply_level <= 1'b0;
    tick(6);
    `CHK(core_on_q, 1'b0, "no shutdown on IO low")
    `CHK(outs, '0, "outputs not high-Z in shutdown")
    `CHK({serial_reset_q, serial_enable_q}, 2'h2, "serial not reset")
    @(posedge clk);
    io_supply_level <= 1'b1;
    tick(6);
    `CHK({boost_run_q, output_enables_q}, 7'h40, "no startup on IO rise")
    wait_mode(tbms_pkg::MODE_ACTIVE, 6100);
    tick(40);
    `CHK(power_state_q, tbms_pkg::MODE_ACTIVE, "retriggered while high")
    @(posedge clk);
    analog_supply_level <= 1'b0;
    tick(6);
    `CHK(core_on_q, 1'b0, "no shutdown on analog low")
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    power_up();
    drive_outputs();
    low_power();
    startup_command();
    supply_loss();
    close_out();
  end
endmodule
`default_nettype wire
